// File: dmfm_pkg.sv
package dmfm_pkg;
	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_DEBOUNCE = 4'h1;
	localparam logic [3:0] OFS_UPDATE = 4'h2;
	localparam logic [3:0] OFS_CUTOFF = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_RESULT = 4'h5;
	localparam logic [3:0] OFS_FIFO = 4'h6;

	// Control field positions
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_DEPTH_LSB = 1;
	localparam int CTRL_DEPTH_W = 4;

	// Status field positions
	localparam int STAT_MODE_BIT = 0;
	localparam int STAT_EMPTY_BIT = 1;
	localparam int STAT_FULL_BIT = 2;
	localparam int STAT_LEVEL_LSB = 8;

	// Reset values
	localparam logic CTRL_OVR_RST = 1'b0;
	localparam logic [3:0] CTRL_DEPTH_RST = 4'h3;
	localparam logic [23:0] DEBOUNCE_RST = 24'h00_0000;
	localparam logic [15:0] UPDATE_RST = 16'h0064;
	localparam logic [23:0] CUTOFF_RST = 24'h0F_FFFF;

	// Timing: reference clock and derived rates
	localparam int REF_CLK_HZ = 10_000_000;
	localparam int SYS_TICK_HZ = 6_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = REF_CLK_HZ / MS_PER_S;

	// Method switch points with hysteresis
	localparam int UPPER_HZ = 6500;
	localparam int LOWER_HZ = 6000;
	localparam logic [23:0] UPPER_PERIOD = 24'(SYS_TICK_HZ / UPPER_HZ);
	localparam logic [15:0] LOWER_PER_MS = 16'(LOWER_HZ / MS_PER_S);
	localparam logic [31:0] TICK_NUMERATOR = 32'(SYS_TICK_HZ);
	localparam logic [15:0] MS_SCALE = 16'(MS_PER_S);

	// Measurement methods
	typedef enum logic {DMFM_PERIOD, DMFM_WINDOW} dmfm_mode_t;
endpackage

// File: dmfm_freq_meter.sv
// Overview of operation
// - One method active, switched automatically by frequency.
// - Below 6500Hz count 6MHz ticks per period.
// - No capture this update: repeat previous result.
// - Every period capture after the first folds into running mean.
// - Each update tick pushes mean-derived result.
// - Above 6000Hz count captures per update window.
// - Hysteresis: up at 6500Hz, down at 6000Hz.
// - Debounce input before any capture counts.
// - Override forces zero once below cutoff.
// - Without override, a stopped input keeps repeating the last result in period method; in window method it reports zero.
//
// Strobed register access and the register offsets were chosen for this implementation.
module dmfm_freq_meter #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Sensor after threshold comparator
	input wire logic sensor_in,
	// Register port
	input wire logic [dmfm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dmfm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dmfm_pkg::DATA_W-1:0] reg_rdata,
	// Measurement outputs
	output logic [31:0] freq_out,
	output logic freq_strobe,
	output logic window_mode
);
	import dmfm_pkg::*;

	localparam int PW = $clog2(FIFO_DEPTH);
	initial begin
		if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) $error("FIFO_DEPTH must be a power of two >= 2");
	end

	// Configuration registers
	logic ovr_q;
	logic [3:0] depth_q;
	logic [23:0] deb_q;
	logic [15:0] upd_q;
	logic [23:0] cutoff_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovr_q <= CTRL_OVR_RST;
			depth_q <= CTRL_DEPTH_RST;
			deb_q <= DEBOUNCE_RST;
			upd_q <= UPDATE_RST;
			cutoff_q <= CUTOFF_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL: begin
					ovr_q <= reg_wdata[CTRL_OVR_BIT];
					depth_q <= reg_wdata[CTRL_DEPTH_LSB +: CTRL_DEPTH_W];
				end
				OFS_DEBOUNCE: deb_q <= reg_wdata[23:0];
				OFS_UPDATE: upd_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
				OFS_CUTOFF: cutoff_q <= reg_wdata[23:0];
				default: ;
			endcase
		end
	end

	// Two-stage synchroniser on the pin
	logic sync1_q, sync2_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= sensor_in;
			sync2_q <= sync1_q;
		end
	end

	// debounce filter
	// Level only accepted after differing for deb_q+1 cycles; both levels filtered alike
	logic stable_q, stable_prev_q;
	logic [23:0] deb_cnt_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stable_q <= 1'b0;
			stable_prev_q <= 1'b0;
			deb_cnt_q <= 24'h00_0000;
		end else begin
			stable_prev_q <= stable_q;
			if (sync2_q == stable_q) begin
				deb_cnt_q <= 24'h00_0000;
			end else if (deb_cnt_q >= deb_q) begin
				stable_q <= sync2_q;
				deb_cnt_q <= 24'h00_0000;
			end else begin
				deb_cnt_q <= deb_cnt_q + 24'h00_0001;
			end
		end
	end
	wire capture = stable_q & ~stable_prev_q;

	// Fractional divider: 6 enables every 10 clocks gives the 6MHz tick
	logic [3:0] phase_q;
	wire [4:0] phase_sum = {1'b0, phase_q} + 5'h06;
	wire tick6 = (phase_sum >= 5'h0A);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) phase_q <= 4'h0;
		else phase_q <= tick6 ? 4'(phase_sum - 5'h0A) : phase_sum[3:0];
	end

	// Millisecond enable and update-period tick
	logic [13:0] ms_cnt_q;
	logic [15:0] upd_cnt_q;
	wire ms_en = (ms_cnt_q == 14'(MS_CYCLES - 1));
	wire upd_tick = ms_en && (upd_cnt_q + 16'h0001 >= upd_q);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ms_cnt_q <= 14'h0000;
			upd_cnt_q <= 16'h0000;
		end else begin
			ms_cnt_q <= ms_en ? 14'h0000 : ms_cnt_q + 14'h0001;
			if (upd_tick) upd_cnt_q <= 16'h0000;
			else if (ms_en) upd_cnt_q <= upd_cnt_q + 16'h0001;
		end
	end

	// Measurement state
	dmfm_mode_t mode_q;
	logic seen_q, fresh_q, valid_q, zeroed_q;
	logic [23:0] per_cnt_q, mean_q;
	logic [3:0] shift_q;
	logic [23:0] win_cnt_q;
	logic [31:0] result_q;

	// running_mean_accumulator update, weight grows to averaging_depth
	wire signed [24:0] mean_diff = $signed({1'b0, per_cnt_q}) - $signed({1'b0, mean_q});
	wire [24:0] mean_step = 25'(mean_diff >>> shift_q);
	wire [23:0] mean_next = mean_q + mean_step[23:0];

	// Serial divider shared by both methods
	logic div_busy_q;
	logic [5:0] div_cnt_q;
	logic [31:0] div_q_q, div_den_q;
	logic [32:0] div_rem_q;
	wire [32:0] rem_sh = {div_rem_q[31:0], div_q_q[31]};
	wire rem_ge = rem_sh >= {1'b0, div_den_q};

	// Push request into the measurement queue
	logic push;
	logic [31:0] push_val;

	// override zero once the period exceeds the cutoff span
	wire force_zero = ovr_q && (mode_q == DMFM_PERIOD) && valid_q && !zeroed_q && (per_cnt_q > cutoff_q);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			// start in period method with nothing averaged
			mode_q <= DMFM_PERIOD;
			seen_q <= 1'b0;
			fresh_q <= 1'b0;
			valid_q <= 1'b0;
			zeroed_q <= 1'b0;
			per_cnt_q <= 24'h00_0000;
			mean_q <= 24'h00_0000;
			shift_q <= 4'h0;
			win_cnt_q <= 24'h00_0000;
			result_q <= 32'h0000_0000;
			div_busy_q <= 1'b0;
			div_cnt_q <= 6'h00;
			div_q_q <= 32'h0000_0000;
			div_den_q <= 32'h0000_0001;
			div_rem_q <= 33'h0_0000_0000;
			push <= 1'b0;
			push_val <= 32'h0000_0000;
		end else begin
			push <= 1'b0;
			// 6MHz ticks since last capture, saturating
			if (capture) per_cnt_q <= 24'h00_0000;
			else if (tick6 && per_cnt_q != 24'hFF_FFFF) per_cnt_q <= per_cnt_q + 24'h00_0001;
			if (upd_tick) win_cnt_q <= capture ? 24'h00_0001 : 24'h00_0000;
			else if (capture && win_cnt_q != 24'hFF_FFFF) win_cnt_q <= win_cnt_q + 24'h00_0001;

			if (capture) begin
				seen_q <= 1'b1;
				zeroed_q <= 1'b0;
				if (seen_q && mode_q == DMFM_PERIOD) begin
					mean_q <= mean_next;
					fresh_q <= 1'b1;
					valid_q <= 1'b1;
					if (shift_q < depth_q) shift_q <= shift_q + 4'h1;
				end
			end

			if (force_zero) begin
				// Abandon any divide in flight so a stale result cannot follow the zero
				div_busy_q <= 1'b0;
				zeroed_q <= 1'b1;
				result_q <= 32'h0000_0000;
				push <= 1'b1;
				push_val <= 32'h0000_0000;
			end else if (div_busy_q) begin
				// One quotient bit per clock
				div_rem_q <= rem_ge ? rem_sh - {1'b0, div_den_q} : rem_sh;
				div_q_q <= {div_q_q[30:0], rem_ge};
				div_cnt_q <= div_cnt_q - 6'h01;
				if (div_cnt_q == 6'h01) begin
					div_busy_q <= 1'b0;
					result_q <= {div_q_q[30:0], rem_ge};
					push <= 1'b1;
					push_val <= {div_q_q[30:0], rem_ge};
				end
			end else if (upd_tick) begin
				fresh_q <= 1'b0;
				if (mode_q == DMFM_PERIOD) begin
					// result from the mean at each update
					if (fresh_q && !zeroed_q) begin
						div_busy_q <= 1'b1;
						div_cnt_q <= 6'd32;
						div_q_q <= TICK_NUMERATOR;
						div_den_q <= {8'h00, mean_q};
						div_rem_q <= 33'h0_0000_0000;
					end else begin
						// no new capture, previous value again
						// held value changes only as new periods reach the mean or the override forces zero
						push <= 1'b1;
						push_val <= result_q;
					end
					// up-switch once the period reaches 6500Hz
					if (valid_q && mean_q <= UPPER_PERIOD) begin
						// single method active at a time
						mode_q <= DMFM_WINDOW;
					end
				end else begin
					div_busy_q <= 1'b1;
					div_cnt_q <= 6'd32;
					div_q_q <= 32'(win_cnt_q) * 32'(MS_SCALE);
					div_den_q <= {16'h0000, upd_q};
					div_rem_q <= 33'h0_0000_0000;
					// back to period method at 6000Hz
					if ({8'h00, win_cnt_q} <= 32'(upd_q) * 32'(LOWER_PER_MS)) begin
						mode_q <= DMFM_PERIOD;
						seen_q <= 1'b0;
						shift_q <= 4'h0;
					end
				end
			end
		end
	end

	// Measurement FIFO; a push into a full queue is dropped
	logic [31:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] wp_q, rp_q;
	logic [PW:0] level_q;
	wire full = (level_q == (PW+1)'(FIFO_DEPTH));
	wire empty = (level_q == '0);
	wire pop = reg_rd && (reg_addr == OFS_FIFO) && !empty;
	wire wr_ok = push && !full;
	always_ff @(posedge ref_clk) begin
		if (wr_ok) fifo_mem[wp_q] <= push_val;
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
			level_q <= '0;
		end else begin
			if (wr_ok) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
			if (wr_ok && !pop) level_q <= level_q + 1'b1;
			else if (pop && !wr_ok) level_q <= level_q - 1'b1;
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (reg_addr)
			OFS_CTRL: begin
				rd_d[CTRL_OVR_BIT] = ovr_q;
				rd_d[CTRL_DEPTH_LSB +: CTRL_DEPTH_W] = depth_q;
			end
			OFS_DEBOUNCE: rd_d[23:0] = deb_q;
			OFS_UPDATE: rd_d[15:0] = upd_q;
			OFS_CUTOFF: rd_d[23:0] = cutoff_q;
			OFS_STATUS: begin
				rd_d[STAT_MODE_BIT] = (mode_q == DMFM_WINDOW);
				rd_d[STAT_EMPTY_BIT] = empty;
				rd_d[STAT_FULL_BIT] = full;
				rd_d[STAT_LEVEL_LSB +: PW+1] = level_q;
			end
			OFS_RESULT: rd_d = result_q;
			OFS_FIFO: rd_d = empty ? 32'h0000_0000 : fifo_mem[rp_q];
			default: ;
		endcase
	end

	// Registered outputs
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
			freq_out <= 32'h0000_0000;
			freq_strobe <= 1'b0;
			window_mode <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
			freq_strobe <= push;
			if (push) freq_out <= push_val;
			window_mode <= (mode_q == DMFM_WINDOW);
		end
	end
endmodule

// File: dmfm_freq_meter_assertions.sv
module dmfm_freq_meter_assertions (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [dmfm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dmfm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dmfm_pkg::DATA_W-1:0] reg_rdata,
	// Measurement outputs
	input wire logic [31:0] freq_out,
	input wire logic freq_strobe,
	input wire logic window_mode
);
	import dmfm_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside read answer");
	a_reset_zero: assert property (disable iff (1'b0) sys_rst |-> !window_mode && !freq_strobe && freq_out == '0)
		else $error("outputs not cleared in reset");
	a_strobe_pulse: assert property (freq_strobe |=> !freq_strobe)
		else $error("result strobe longer than one cycle");
	a_out_hold: assert property (!freq_strobe |-> $stable(freq_out))
		else $error("result changed without strobe");
	a_mode_settle: assert property ($changed(window_mode) |=> $stable(window_mode) [*8])
		else $error("method changed twice in a row");
	a_mode_status: assert property (reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[STAT_MODE_BIT] == window_mode)
		else $error("status method bit differs from method output");
	a_result_read: assert property ((reg_rd && reg_addr == OFS_RESULT) ##1 (!freq_strobe ##1 !freq_strobe)
		|-> $past(reg_rdata) == freq_out)
		else $error("result register differs from result output");
	a_update_min: assert property ((reg_wr && reg_addr == OFS_UPDATE && reg_wdata[15:0] == '0)
		##2 (reg_rd && reg_addr == OFS_UPDATE) |=> reg_rdata[15:0] == 16'h0001)
		else $error("zero update interval not stored as one");
	a_unmapped_rd: assert property (reg_rd && reg_addr > OFS_FIFO |=> reg_rdata == '0)
		else $error("unmapped read not zero");
endmodule

bind dmfm_freq_meter dmfm_freq_meter_assertions u_dmfm_freq_meter_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.freq_out(freq_out), .freq_strobe(freq_strobe), .window_mode(window_mode));

// File: dmfm_sensor_model.sv
module dmfm_sensor_model (
	// Clock
	input wire logic ref_clk,
	// Half period in clocks, zero stops the sensor
	input wire logic [15:0] half_cycles,
	// Thresholded sensor level
	output logic sensor_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_q = 16'h0000;
	initial sensor_in = 1'b0;
	// Square wave; a stopped sensor rests low so no stray edge appears
	always @(posedge ref_clk) begin
		cnt_q <= (half_cycles == 16'h0000 || cnt_q >= half_cycles - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
		if (half_cycles == 16'h0000) begin
			sensor_in <= 1'b0;
		end else if (cnt_q >= half_cycles - 16'h0001) begin
			sensor_in <= ~sensor_in;
		end
	end
endmodule

// File: dmfm_freq_meter_tb.sv
module dmfm_freq_meter_tb import dmfm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [3:0] addr; logic [31:0] exp; logic [31:0] mask; int tol;} dmfm_note_t;
	logic ref_clk = 1'b0, sys_rst = 1'b0, sensor_in, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic freq_strobe, window_mode;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, freq_out, seed, seen;
	logic [15:0] half_q = 16'h0000;
	logic [31:0] rst_exp [8] = '{32'h0000_0006, 32'h0000_0000, 32'h0000_0064, 32'h000F_FFFF,
		32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
	int failures = 0, compares = 0;
	dmfm_note_t notes[$];
	dmfm_note_t cur;

	// Clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	dmfm_freq_meter u_dmfm_freq_meter (.ref_clk(ref_clk), .sys_rst(sys_rst), .sensor_in(sensor_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.freq_out(freq_out), .freq_strobe(freq_strobe), .window_mode(window_mode));
	dmfm_sensor_model u_dmfm_sensor_model (.ref_clk(ref_clk), .half_cycles(half_q), .sensor_in(sensor_in));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// One bus cycle, then one idle cycle so strobes never re-assert in one step
	task automatic acc(input logic wr_en, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input int tol);
		dmfm_note_t n;
		n.addr = a;
		n.exp = d;
		n.mask = m;
		n.tol = tol;
		reg_addr <= a;
		reg_wdata <= d;
		if (wr_en) begin
			reg_wr <= 1'b1;
		end else begin
			reg_rd <= 1'b1;
			notes.push_back(n);
		end
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 32'h0000_0000, 0);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input int tol);
		acc(1'b0, a, e, m, tol);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic final_report;
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Read answer stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_d) begin
			cur = notes.pop_front();
			seen = reg_rdata & cur.mask;
			compares++;
			if (^seen === 1'bx || seen > cur.exp + cur.tol || seen + cur.tol < cur.exp) begin
				failures++;
				$display("[ERR] reg %0h exp %0d seen %0d", cur.addr, cur.exp, seen);
			end
		end
		rd_d <= reg_rd;
	end

	// Watchdog just above the roughly 95500 cycles the scenarios need
	initial begin
		wait_cyc(100000);
		failures++;
		final_report();
	end

	initial begin
		seed = 32'h0000_0053;
		// Real edge on reset so every flop is cleared before the first clock
		#1 sys_rst = 1'b1;
		wait_cyc(16);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) rd(4'(i), rst_exp[i], 32'hFFFF_FFFF, 0);
		seed = xs(seed);
		wr(OFS_DEBOUNCE, seed);
		rd(OFS_DEBOUNCE, seed & 32'h00FF_FFFF, 32'hFFFF_FFFF, 0);
		wr(OFS_RESULT, seed);
		rd(OFS_RESULT, 32'h0000_0000, 32'hFFFF_FFFF, 0);
		seed = xs(seed);
		wr(OFS_DEBOUNCE, 32'(seed[4:0]));
		wr(OFS_UPDATE, 32'h0000_0000);
		rd(OFS_UPDATE, 32'h0000_0001, 32'h0000_FFFF, 0);
		wr(OFS_CTRL, 32'h0000_0000);
		// Inside the hysteresis band from below: stays in period method
		half_q <= 16'h030D;
		wait_cyc(10900);
		rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001, 0);
		rd(OFS_RESULT, 32'h0000_1902, 32'hFFFF_FFFF, 100);
		// Override forces zero well before the next update tick
		wr(OFS_CUTOFF, 32'h0000_04B0);
		wr(OFS_UPDATE, 32'h0000_0003);
		wr(OFS_CTRL, 32'h0000_0001);
		half_q <= 16'h0000;
		wait_cyc(2500);
		rd(OFS_RESULT, 32'h0000_0000, 32'hFFFF_FFFF, 0);
		wr(OFS_CTRL, 32'h0000_0000);
		// Fast input moves to window counting
		wr(OFS_UPDATE, 32'h0000_0001);
		half_q <= 16'h01F4;
		wait_cyc(21000);
		rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0001, 0);
		// Back into the band from above: window method holds
		// Three ms windows keep the band count clear of the down-switch limit
		wr(OFS_UPDATE, 32'h0000_0003);
		half_q <= 16'h030D;
		wait_cyc(61000);
		rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0001, 0);
		rd(OFS_RESULT, 32'h0000_1902, 32'hFFFF_FFFF, 400);
		wait_cyc(4);
		compares += 2;
		if (window_mode !== 1'b1) begin
			failures++;
			$display("[ERR] window_mode exp 1 seen %0b", window_mode);
		end
		if (^freq_out === 1'bx || freq_out > 32'h0000_1A92 || freq_out < 32'h0000_1772) begin
			failures++;
			$display("[ERR] freq_out exp %0d seen %0d", 32'h0000_1902, freq_out);
		end
		final_report();
	end
endmodule
